// file: hdl/alarm_match.sv
`timescale 1ns/10ps
`default_nettype none
`include "logger_rtc_defines.svh"

module alarm_match (
  logger_core_if.matcher link
);
  logic sec_ok;
  logic min_ok;
  logic hour_ok;
  logic day_ok;

  // A set mask drops its field from the compare, giving the per-second, minute,
  // hour, day and week periods; fields compare as stored BCD.
  assign sec_ok = link.alarm[0][`ALARM_MASK_BIT] | (link.alarm[0][6:0] == link.seconds[6:0]);
  assign min_ok = link.alarm[1][`ALARM_MASK_BIT] | (link.alarm[1][6:0] == link.minutes[6:0]);
  assign hour_ok = link.alarm[2][`ALARM_MASK_BIT] | (link.alarm[2][6:0] == link.hours[6:0]);
  assign day_ok = link.alarm[3][`ALARM_MASK_BIT] | (link.alarm[3][2:0] == link.weekday[2:0]);
  assign link.alarm_hit = sec_ok & min_ok & hour_ok & day_ok;
endmodule : alarm_match

`default_nettype wire

// file: hdl/logger_core_if.sv
`timescale 1ns/10ps
`default_nettype none

interface logger_core_if;
  logic [7:0] seconds;
  logic [7:0] minutes;
  logic [7:0] hours;
  logic [7:0] weekday;
  logic [3:0][7:0] alarm;
  logic alarm_hit;
  logic conv_below;
  logic conv_above;
  logic [7:0] conv_raw;
  logic [7:0] temp_code;
  logic [5:0] temp_bin;

  modport core (
    output seconds, minutes, hours, weekday, alarm, conv_below, conv_above, conv_raw,
    input alarm_hit, temp_code, temp_bin
  );
  modport matcher (
    input seconds, minutes, hours, weekday, alarm,
    output alarm_hit
  );
  modport mapper (
    input conv_below, conv_above, conv_raw,
    output temp_code, temp_bin
  );
endinterface : logger_core_if

`default_nettype wire

// file: hdl/logger_rtc_alarm_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "logger_rtc_defines.svh"

module logger_rtc_alarm_control (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic osc_second,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic conv_valid,
  input wire logic conv_below,
  input wire logic conv_above,
  input wire logic [7:0] conv_code,
  input wire logic memory_cleared_flag,
  output logic timer_alarm_flag,
  output logic low_temp_flag,
  output logic high_temp_flag,
  output logic mission_active,
  output logic search_hit,
  output logic oscillator_disable,
  output logic memory_clear_arm,
  output logic log_wrap_enable,
  output logic [7:0] sample_interval_minutes,
  output logic [5:0] hist_bin,
  output logic hist_strobe
);

  logger_rtc_pkg::core_state_s s_q;
  logger_rtc_pkg::core_state_s s_d;

  logger_core_if link ();

  logic tick;
  logic leap;
  logic mode12;
  logic carry_min;
  logic carry_hour;
  logic carry_day;
  logic carry_month;
  logic carry_year;
  logic [7:0] hour_in;
  logic [7:0] hour_inc;
  logic [7:0] month_in;
  logic [7:0] month_last_day;
  logic [7:0] month_next;
  logic guarded_write;
  logic status_write;
  logic rate_write;

  alarm_match u_alarm_match (
    .link(link)
  );

  temp_code_map u_temp_code_map (
    .link(link)
  );

  assign link.seconds = s_q.seconds;
  assign link.minutes = s_q.minutes;
  assign link.hours = s_q.hours;
  assign link.weekday = s_q.weekday;
  assign link.alarm = s_q.alarm;
  assign link.conv_below = conv_below;
  assign link.conv_above = conv_above;
  assign link.conv_raw = conv_code;

  // Steps one BCD byte; callers handle the 59, 23, 12 and 99 wraps themselves.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // A BCD year is a multiple of four when an odd tens digit pairs with 2 or 6,
  // or an even one with 0, 4 or 8; 00 counts, so 2100 would be wrong.
  function automatic logic year_is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : year_is_leap

  // Last day of a BCD month; illegal month codes fall back to 31 days.
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic lp);
    unique case (m)
      8'h02: return lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : last_day

  always_comb begin
    s_d = s_q;
    tick = 1'b0;
    carry_min = 1'b0;
    carry_hour = 1'b0;
    carry_day = 1'b0;
    carry_month = 1'b0;
    carry_year = 1'b0;
    leap = year_is_leap(s_q.year);
    mode12 = s_q.hours[`HOURS_MODE12_BIT];
    hour_in = mode12 ? {3'b000, s_q.hours[4:0]} : {2'b00, s_q.hours[5:0]};
    hour_inc = bcd_inc(hour_in);
    month_in = {3'b000, s_q.month_century[4:0]};
    month_last_day = last_day(month_in, leap);
    month_next = bcd_inc(month_in);
    guarded_write = reg_wr && (reg_addr >= `ADDR_SECONDS) && (reg_addr <= `ADDR_LAST_GUARDED);
    status_write = reg_wr && (reg_addr == `ADDR_STATUS);
    rate_write = reg_wr && (reg_addr == `ADDR_SAMPLE_INTERVAL) && (reg_wdata != 8'h00);

    // The pin comes from the oscillator domain; only tick_sync onward is looked at.
    s_d.tick_meta = osc_second;
    s_d.tick_sync = s_q.tick_meta;
    s_d.tick_prev = s_q.tick_sync;
    s_d.rd_valid = 1'b0;
    s_d.eval_pending = 1'b0;
    s_d.hist_strobe = 1'b0;

    // Edges arriving while the oscillator is disabled are dropped, not queued.
    tick = s_q.tick_sync && !s_q.tick_prev && !s_q.setup[`SETUP_OSC_DISABLE_BIT];

    if (tick) begin
      s_d.advanced = 1'b1;
      s_d.eval_pending = 1'b1;
      carry_min = (s_q.seconds == 8'h59);
      s_d.seconds = carry_min ? 8'h00 : bcd_inc(s_q.seconds);
      if (carry_min) begin
        carry_hour = (s_q.minutes == 8'h59);
        s_d.minutes = carry_hour ? 8'h00 : bcd_inc(s_q.minutes);
      end
      if (carry_hour) begin
        if (mode12) begin
          // Twelve follows eleven and flips the PM bit; midnight is 12 AM.
          if (hour_in == 8'h12) begin
            s_d.hours = {s_q.hours[7:5], 5'h01};
          end else if (hour_in == 8'h11) begin
            s_d.hours = {s_q.hours[7:6], ~s_q.hours[`HOURS_PM_BIT], 5'h12};
            carry_day = s_q.hours[`HOURS_PM_BIT];
          end else begin
            s_d.hours = {s_q.hours[7:5], hour_inc[4:0]};
          end
        end else begin
          // Bit 5 is the twenty-hours digit here.
          if (hour_in == 8'h23) begin
            s_d.hours = {s_q.hours[7:6], 6'h00};
            carry_day = 1'b1;
          end else begin
            s_d.hours = {s_q.hours[7:6], hour_inc[5:0]};
          end
        end
      end
      if (carry_day) begin
        // No weekday meaning is attached; the count just wraps.
        if (s_q.weekday[2:0] == 3'h7) begin
          s_d.weekday = 8'h01;
        end else begin
          s_d.weekday = {5'h00, s_q.weekday[2:0] + 3'h1};
        end
        carry_month = (s_q.day_of_month == month_last_day);
        s_d.day_of_month = carry_month ? 8'h01 : bcd_inc(s_q.day_of_month);
      end
      if (carry_month) begin
        carry_year = (month_in == 8'h12);
        s_d.month_century = {s_q.month_century[`CENTURY_BIT], 2'b00,
                             carry_year ? 5'h01 : month_next[4:0]};
      end
      if (carry_year) begin
        if (s_q.year == 8'h99) begin
          s_d.year = 8'h00;
          s_d.month_century[`CENTURY_BIT] = ~s_q.month_century[`CENTURY_BIT];
        end else begin
          s_d.year = bcd_inc(s_q.year);
        end
      end
    end

    // Software clears flags by writing 0; a set in the same cycle wins below.
    if (status_write) begin
      s_d.timer_alarm = s_q.timer_alarm & reg_wdata[`STATUS_TIMER_ALARM_BIT];
      s_d.high_temp = s_q.high_temp & reg_wdata[`STATUS_HIGH_TEMP_BIT];
      s_d.low_temp = s_q.low_temp & reg_wdata[`STATUS_LOW_TEMP_BIT];
    end

    // The compare looks at the time registered on the tick, one cycle later.
    if (s_q.eval_pending && link.alarm_hit) begin
      s_d.timer_alarm = 1'b1;
    end

    // Threshold flags only rise while logging, so stale readings never trip a search.
    if (conv_valid) begin
      s_d.temp_readout = link.temp_code;
      s_d.hist_bin = link.temp_bin;
      s_d.hist_strobe = s_q.mission;
      if (s_q.mission && (link.temp_code <= s_q.low_thr)) begin
        s_d.low_temp = 1'b1;
      end
      if (s_q.mission && (link.temp_code >= s_q.high_thr)) begin
        s_d.high_temp = 1'b1;
      end
    end

    // Writes override a tick update of the same register in the same cycle.
    if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_SECONDS: s_d.seconds = reg_wdata & `MASK_SECONDS;
        `ADDR_MINUTES: s_d.minutes = reg_wdata & `MASK_MINUTES;
        `ADDR_HOURS: s_d.hours = reg_wdata & `MASK_HOURS;
        `ADDR_WEEKDAY: s_d.weekday = reg_wdata & `MASK_WEEKDAY;
        `ADDR_DAY_OF_MONTH: s_d.day_of_month = reg_wdata & `MASK_DAY_OF_MONTH;
        `ADDR_MONTH_CENTURY: s_d.month_century = reg_wdata & `MASK_MONTH_CENTURY;
        `ADDR_YEAR: s_d.year = reg_wdata & `MASK_YEAR;
        `ADDR_ALARM_SECONDS: s_d.alarm[0] = reg_wdata;
        `ADDR_ALARM_MINUTES: s_d.alarm[1] = reg_wdata;
        `ADDR_ALARM_HOURS: s_d.alarm[2] = reg_wdata;
        `ADDR_ALARM_WEEKDAY: s_d.alarm[3] = reg_wdata & `MASK_ALARM_WEEKDAY;
        `ADDR_LOW_THRESHOLD: s_d.low_thr = reg_wdata;
        `ADDR_HIGH_THRESHOLD: s_d.high_thr = reg_wdata;
        `ADDR_SAMPLE_INTERVAL: s_d.sample_interval = reg_wdata;
        `ADDR_SETUP_BITS: s_d.setup = reg_wdata & `MASK_SETUP_BITS;
        default: begin
        end
      endcase
    end

    // While logging, any write to the guarded page range stops the mission;
    // the setup register is one of them.
    if (guarded_write && s_q.mission) begin
      s_d.mission = 1'b0;
    end

    // Start needs cleared memory, the enable low and at least one clock advance.
    if (rate_write && memory_cleared_flag && !s_q.setup[`SETUP_MISSION_EN_N_BIT]
        && s_q.advanced && !s_q.mission) begin
      s_d.mission = 1'b1;
    end

    // Read data is registered, so a read beside a write returns the old value.
    if (reg_rd) begin
      s_d.rd_valid = 1'b1;
      unique case (reg_addr)
        `ADDR_SECONDS: s_d.rd_data = s_q.seconds;
        `ADDR_MINUTES: s_d.rd_data = s_q.minutes;
        `ADDR_HOURS: s_d.rd_data = s_q.hours;
        `ADDR_WEEKDAY: s_d.rd_data = s_q.weekday;
        `ADDR_DAY_OF_MONTH: s_d.rd_data = s_q.day_of_month;
        `ADDR_MONTH_CENTURY: s_d.rd_data = s_q.month_century;
        `ADDR_YEAR: s_d.rd_data = s_q.year;
        `ADDR_ALARM_SECONDS: s_d.rd_data = s_q.alarm[0];
        `ADDR_ALARM_MINUTES: s_d.rd_data = s_q.alarm[1];
        `ADDR_ALARM_HOURS: s_d.rd_data = s_q.alarm[2];
        `ADDR_ALARM_WEEKDAY: s_d.rd_data = s_q.alarm[3];
        `ADDR_LOW_THRESHOLD: s_d.rd_data = s_q.low_thr;
        `ADDR_HIGH_THRESHOLD: s_d.rd_data = s_q.high_thr;
        `ADDR_SAMPLE_INTERVAL: s_d.rd_data = s_q.sample_interval;
        `ADDR_SETUP_BITS: s_d.rd_data = s_q.setup;
        `ADDR_TEMP_READOUT: s_d.rd_data = s_q.temp_readout;
        `ADDR_STATUS: begin
          s_d.rd_data = `RESET_ZERO_BYTE;
          s_d.rd_data[`STATUS_TIMER_ALARM_BIT] = s_q.timer_alarm;
          s_d.rd_data[`STATUS_HIGH_TEMP_BIT] = s_q.high_temp;
          s_d.rd_data[`STATUS_LOW_TEMP_BIT] = s_q.low_temp;
          s_d.rd_data[`STATUS_MISSION_BIT] = s_q.mission;
          s_d.rd_data[`STATUS_MEM_CLEARED_BIT] = memory_cleared_flag;
        end
        default: s_d.rd_data = `RESET_ZERO_BYTE;
      endcase
    end

    // The timer alarm flag usually stays set in a mission, so its search enable
    // is normally left off by software.
    s_d.search_hit = s_q.mission && (
      (s_q.setup[`SETUP_TIMER_SEARCH_BIT] && s_q.timer_alarm) ||
      (s_q.setup[`SETUP_LOW_SEARCH_BIT] && s_q.low_temp) ||
      (s_q.setup[`SETUP_HIGH_SEARCH_BIT] && s_q.high_temp));
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.seconds <= `RESET_SECONDS;
      s_q.minutes <= `RESET_MINUTES;
      s_q.hours <= `RESET_HOURS;
      s_q.weekday <= `RESET_WEEKDAY;
      s_q.day_of_month <= `RESET_DAY_OF_MONTH;
      s_q.month_century <= `RESET_MONTH_CENTURY;
      s_q.year <= `RESET_YEAR;
      s_q.setup <= `RESET_ZERO_BYTE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Every output is a bare flop of the state struct, with no logic after it.
  assign reg_rdata = s_q.rd_data;
  assign reg_rvalid = s_q.rd_valid;
  assign timer_alarm_flag = s_q.timer_alarm;
  assign low_temp_flag = s_q.low_temp;
  assign high_temp_flag = s_q.high_temp;
  assign mission_active = s_q.mission;
  assign search_hit = s_q.search_hit;
  assign oscillator_disable = s_q.setup[`SETUP_OSC_DISABLE_BIT];
  assign memory_clear_arm = s_q.setup[`SETUP_MEM_CLEAR_ARM_BIT];
  assign log_wrap_enable = s_q.setup[`SETUP_LOG_WRAP_BIT];
  assign sample_interval_minutes = s_q.sample_interval;
  assign hist_bin = s_q.hist_bin;
  assign hist_strobe = s_q.hist_strobe;

endmodule : logger_rtc_alarm_control

`default_nettype wire

// file: hdl/logger_rtc_defines.svh
`ifndef LOGGER_RTC_DEFINES_SVH
`define LOGGER_RTC_DEFINES_SVH

// Register page addresses.
`define ADDR_SECONDS 16'h0200
`define ADDR_MINUTES 16'h0201
`define ADDR_HOURS 16'h0202
`define ADDR_WEEKDAY 16'h0203
`define ADDR_DAY_OF_MONTH 16'h0204
`define ADDR_MONTH_CENTURY 16'h0205
`define ADDR_YEAR 16'h0206
`define ADDR_ALARM_SECONDS 16'h0207
`define ADDR_ALARM_MINUTES 16'h0208
`define ADDR_ALARM_HOURS 16'h0209
`define ADDR_ALARM_WEEKDAY 16'h020A
`define ADDR_LOW_THRESHOLD 16'h020B
`define ADDR_HIGH_THRESHOLD 16'h020C
`define ADDR_SAMPLE_INTERVAL 16'h020D
`define ADDR_SETUP_BITS 16'h020E
`define ADDR_TEMP_READOUT 16'h0211
`define ADDR_LAST_GUARDED 16'h0213
`define ADDR_STATUS 16'h0214

// Writable bits per register; constant-zero bits are dropped on write.
`define MASK_SECONDS 8'h7F
`define MASK_MINUTES 8'h7F
`define MASK_HOURS 8'h7F
`define MASK_WEEKDAY 8'h07
`define MASK_DAY_OF_MONTH 8'h3F
`define MASK_MONTH_CENTURY 8'h9F
`define MASK_YEAR 8'hFF
`define MASK_ALARM_WEEKDAY 8'h87
`define MASK_SETUP_BITS 8'hDF

// Field positions.
`define HOURS_MODE12_BIT 6
`define HOURS_PM_BIT 5
`define CENTURY_BIT 7
`define ALARM_MASK_BIT 7
`define SETUP_OSC_DISABLE_BIT 7
`define SETUP_MEM_CLEAR_ARM_BIT 6
`define SETUP_MISSION_EN_N_BIT 4
`define SETUP_LOG_WRAP_BIT 3
`define SETUP_LOW_SEARCH_BIT 2
`define SETUP_HIGH_SEARCH_BIT 1
`define SETUP_TIMER_SEARCH_BIT 0
`define STATUS_TIMER_ALARM_BIT 0
`define STATUS_HIGH_TEMP_BIT 1
`define STATUS_LOW_TEMP_BIT 2
`define STATUS_MISSION_BIT 5
`define STATUS_MEM_CLEARED_BIT 6

// Reset values.
`define RESET_SECONDS 8'h00
`define RESET_MINUTES 8'h00
`define RESET_HOURS 8'h00
`define RESET_WEEKDAY 8'h01
`define RESET_DAY_OF_MONTH 8'h01
`define RESET_MONTH_CENTURY 8'h01
`define RESET_YEAR 8'h00
`define RESET_ZERO_BYTE 8'h00

// Temperature code limits.
`define TEMP_CODE_BELOW 8'h00
`define TEMP_CODE_ABOVE 8'hFF
`define TEMP_CODE_MIN_VALID 8'h01
`define TEMP_CODE_MAX_VALID 8'hFE

`endif

// file: hdl/logger_rtc_pkg.sv
package logger_rtc_pkg;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    byte_t seconds;
    byte_t minutes;
    byte_t hours;
    byte_t weekday;
    byte_t day_of_month;
    byte_t month_century;
    byte_t year;
    logic [3:0][7:0] alarm;
    byte_t low_thr;
    byte_t high_thr;
    byte_t sample_interval;
    byte_t setup;
    byte_t temp_readout;
    logic [5:0] hist_bin;
    logic hist_strobe;
    logic timer_alarm;
    logic low_temp;
    logic high_temp;
    logic mission;
    logic advanced;
    logic tick_meta;
    logic tick_sync;
    logic tick_prev;
    logic eval_pending;
    byte_t rd_data;
    logic rd_valid;
    logic search_hit;
  } core_state_s;

endpackage : logger_rtc_pkg

// file: hdl/temp_code_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "logger_rtc_defines.svh"

module temp_code_map (
  logger_core_if.mapper link
);
  // Codes stay raw eighths of a degree; the range offset is applied by software.
  always_comb begin
    if (link.conv_below) begin
      link.temp_code = `TEMP_CODE_BELOW;
    end else if (link.conv_above) begin
      link.temp_code = `TEMP_CODE_ABOVE;
    end else if (link.conv_raw < `TEMP_CODE_MIN_VALID) begin
      link.temp_code = `TEMP_CODE_MIN_VALID;
    end else if (link.conv_raw > `TEMP_CODE_MAX_VALID) begin
      link.temp_code = `TEMP_CODE_MAX_VALID;
    end else begin
      link.temp_code = link.conv_raw;
    end
  end

  // Four codes per bin: 00h-03h land in bin 0, FCh-FFh in bin 63.
  assign link.temp_bin = link.temp_code[7:2];
endmodule : temp_code_map

`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input wire logic clock,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse so a stale value is never mistaken for a held one.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // A missing valid pulse returns inverted data, so the caller's compare catches it.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : ~reg_rdata;
    reg_addr = ~a;
  endtask : rd
endmodule : host_model

`default_nettype wire

// file: tb/logger_rtc_props.sv
`timescale 1ns/10ps
`default_nettype none

module logger_rtc_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_valid,
  input wire logic conv_below,
  input wire logic conv_above,
  input wire logic timer_alarm_flag,
  input wire logic mission_active,
  input wire logic oscillator_disable,
  input wire logic log_wrap_enable,
  input wire logic [7:0] sample_interval_minutes,
  input wire logic [5:0] hist_bin
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_sec_zero;
    reg_rd && reg_addr == 16'h0200 |=> reg_rdata[7] == 1'b0;
  endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("seconds top bit read as one");
  property p_weekday;
    reg_rd && reg_addr == 16'h0203 |=> reg_rdata inside {[8'h01:8'h07]};
  endproperty
  a_weekday: assert property (p_weekday) else $error("weekday out of range");
  property p_setup_b5;
    reg_rd && reg_addr == 16'h020E |=> !reg_rdata[5];
  endproperty
  a_setup_b5: assert property (p_setup_b5) else $error("setup bit 5 read as one");
  property p_setup_out;
    reg_wr && reg_addr == 16'h020E
      |=> {oscillator_disable, log_wrap_enable} == {$past(reg_wdata[7]), $past(reg_wdata[3])};
  endproperty
  a_setup_out: assert property (p_setup_out) else $error("setup outputs wrong");
  property p_rate;
    reg_wr && reg_addr == 16'h020D && !mission_active
      |=> sample_interval_minutes == $past(reg_wdata);
  endproperty
  a_rate: assert property (p_rate) else $error("sample interval not stored");
  property p_mission_end;
    mission_active && reg_wr && reg_addr == 16'h020E |=> !mission_active;
  endproperty
  a_mission_end: assert property (p_mission_end) else $error("mission kept running");
  property p_below;
    conv_valid && conv_below |=> hist_bin == 6'h00;
  endproperty
  a_below: assert property (p_below) else $error("low result not in bin zero");
  property p_above;
    conv_valid && conv_above && !conv_below |=> hist_bin == 6'h3F;
  endproperty
  a_above: assert property (p_above) else $error("high result not in top bin");
  property p_sticky;
    timer_alarm_flag && !(reg_wr && reg_addr == 16'h0214) |=> timer_alarm_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm flag dropped");

  c_mission: cover property ($rose(mission_active));
  c_alarm: cover property ($rose(timer_alarm_flag));
  c_conv: cover property (conv_valid && mission_active);
endmodule : logger_rtc_props

bind logger_rtc_alarm_control logger_rtc_props props (
  .clock(clock),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .conv_valid(conv_valid),
  .conv_below(conv_below),
  .conv_above(conv_above),
  .timer_alarm_flag(timer_alarm_flag),
  .mission_active(mission_active),
  .oscillator_disable(oscillator_disable),
  .log_wrap_enable(log_wrap_enable),
  .sample_interval_minutes(sample_interval_minutes),
  .hist_bin(hist_bin)
);

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en, osc_second, conv_valid, conv_below, conv_above, memory_cleared_flag;
  logic [7:0] conv_code;
  logic [15:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_wdata, reg_rdata, sample_interval_minutes;
  logic timer_alarm_flag, low_temp_flag, high_temp_flag, mission_active, search_hit;
  logic oscillator_disable, memory_clear_arm, log_wrap_enable, hist_strobe;
  logic [5:0] hist_bin;
  int err_count = 0;
  int samples_checked = 0;

  always #5 clock = ~clock;

  logger_rtc_alarm_control dut (.*);
  host_model host (.*);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic tick();
    @(negedge clock);
    osc_second = 1'b1;
    repeat (6) @(negedge clock);
    osc_second = 1'b0;
    repeat (2) @(negedge clock);
  endtask : tick

  task automatic t_regs();
    logic [119:0] rv = 120'h000000010101000000000000000000;
    logic [119:0] mk = 120'h7F7F7F073F9FFFFFFFFF87FFFFFFDF;
    for (int i = 0; i < 15; i++) begin
      rdc(16'h0200 + 16'(i), rv[8*(14-i) +: 8]);
    end
    for (int i = 0; i < 15; i++) begin
      host.wr(16'h0200 + 16'(i), 8'hFF);
      rdc(16'h0200 + 16'(i), mk[8*(14-i) +: 8]);
    end
    host.wr(16'h020E, 8'h00);
    rdc(16'h0300, 8'h00);
    $display("register test done");
  endtask : t_regs

  task automatic t_cal();
    logic [55:0] ld [6] = '{56'h59592307288292, 56'h59592303288203, 56'h59592305311299,
                            56'h59597102308405, 56'h59595102158605, 56'h59592301288200};
    logic [55:0] ex [6] = '{56'h00000001298292, 56'h00000004018303, 56'h00000006018100,
                            56'h00005203018505, 56'h00007202158605, 56'h00000002298200};
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 7; i++) begin
        host.wr(16'h0200 + 16'(i), ld[k][8*(6-i) +: 8]);
      end
      tick();
      for (int i = 0; i < 7; i++) begin
        rdc(16'h0200 + 16'(i), ex[k][8*(6-i) +: 8]);
      end
    end
    $display("calendar test done");
  endtask : t_cal

  task automatic t_alarm();
    logic [32:0] al [8] = '{33'h180808080, 33'h159808080, 33'h159598080, 33'h159592380,
                            33'h159592307, 33'h059592306, 33'h059582380, 33'h058808080};
    for (int k = 0; k < 8; k++) begin
      host.wr(16'h0214, 8'h00);
      for (int i = 0; i < 7; i++) begin
        host.wr(16'h0200 + 16'(i), 8'(56'h58592307100110 >> (8*(6-i))));
      end
      for (int i = 0; i < 4; i++) begin
        host.wr(16'h0207 + 16'(i), al[k][8*(3-i) +: 8]);
      end
      tick();
      chk(8'(timer_alarm_flag), 8'(al[k][32]));
      if (al[k][32]) begin
        host.wr(16'h0214, 8'h00);
        repeat (10) @(negedge clock);
        chk(8'(timer_alarm_flag), 8'h00);
      end
    end
    $display("alarm test done");
  endtask : t_alarm

  task automatic t_osc();
    host.wr(16'h020E, 8'hC8);
    chk(8'({oscillator_disable, memory_clear_arm, log_wrap_enable}), 8'h07);
    host.wr(16'h0200, 8'h10);
    tick();
    rdc(16'h0200, 8'h10);
    host.wr(16'h020E, 8'h00);
    tick();
    rdc(16'h0200, 8'h11);
    clk_en = 1'b0;
    tick();
    clk_en = 1'b1;
    rdc(16'h0200, 8'h11);
    $display("oscillator test done");
  endtask : t_osc

  task automatic conv(input logic [17:0] c);
    @(negedge clock);
    conv_valid = 1'b1;
    {conv_below, conv_above, conv_code} = c[17:8];
    @(negedge clock);
    conv_valid = 1'b0;
    conv_code = ~conv_code;
    chk(8'(hist_strobe), 8'h01);
    chk(8'(hist_bin), 8'(c[7:2]));
    rdc(16'h0211, c[7:0]);
  endtask : conv

  task automatic t_mission();
    host.wr(16'h020D, 8'h05);
    chk(8'(mission_active), 8'h00);
    memory_cleared_flag = 1'b1;
    host.wr(16'h020E, 8'h10);
    host.wr(16'h020D, 8'h05);
    chk(8'(mission_active), 8'h00);
    host.wr(16'h020E, 8'h01);
    host.wr(16'h020B, 8'h40);
    host.wr(16'h020C, 8'hC0);
    host.wr(16'h0207, 8'h80);
    host.wr(16'h0214, 8'h00);
    host.wr(16'h020D, 8'h0A);
    chk(8'(mission_active), 8'h01);
    chk(sample_interval_minutes, 8'h0A);
    tick();
    chk(8'(search_hit), 8'h01);
    rdc(16'h0214, 8'h61);
    conv(18'h04444);
    chk(8'({low_temp_flag, high_temp_flag}), 8'h00);
    conv(18'h28000);
    conv(18'h180FF);
    conv(18'h38000);
    conv(18'h00001);
    chk(8'({low_temp_flag, high_temp_flag}), 8'h03);
    host.wr(16'h020E, 8'h00);
    chk(8'(mission_active), 8'h00);
    $display("mission test done");
  endtask : t_mission

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    osc_second = 1'b0;
    conv_valid = 1'b0;
    conv_below = 1'b0;
    conv_above = 1'b0;
    conv_code = 8'h00;
    memory_cleared_flag = 1'b0;
    clk_en = 1'b1;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    t_regs();
    t_cal();
    t_alarm();
    t_osc();
    t_mission();
    close_out();
  end

  // Whole run needs well under a tenth of this span.
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule : testbench

`default_nettype wire
